// ### rtl/adc_chop_standby_detect_ctrl.v
`timescale 1ns/1ps
`include "adc_ctrl_map.vh"

// Contract
// - Alternate polarity, average consecutive opposite pairs
// - Reset filter on every polarity swap
// - Delay field selects 2 to 65536 ticks
// - Steady period is delay plus 3*OVERSAMPLING_RATIO
// - Data ready falls on each chopped result
// - Restart on sync fall or OVERSAMPLING_RATIO change
// - First result: two delays, 6*OVERSAMPLING_RATIO, 44
// - Phase calibration ignored while chopping
// - DC test yields nothing while chopping
// - Two-bit power level, both conversion modes
// - Standby command disables channels, keeps settings
// - Wakeup starts sampling after 8 ticks
// - Detect entry only by short pulse in standby
// - Detect compares magnitude, notifies, returns standby
// - Detect runs on oscillator, results stay internal
// - Threshold is 24 bits from two registers
// - Three-bit length selects 128 to 3584
// - Three-bit count sets hits for detection
// - All-channels bit selects all or any
// - Detect enable gates, channel enables select
// - SPI mode 1 full-duplex slave
// - Long sync low resets until high
module adc_chop_standby_detect_ctrl (
  // Clock and reset
  input  wire        i_mclk,
  input  wire        i_srst,
  // Pins from the host
  input  wire        i_converter_clock_in,
  input  wire        i_sync_reset_n,
  input  wire        i_sclk,
  input  wire        i_cs_n,
  input  wire        i_din,
  input  wire        i_osc_clk,
  // Pins to the host
  output reg         o_dout,
  output wire        o_dout_oe,
  output reg         o_data_ready_n,
  // Configuration
  input  wire        i_chop_enable,
  input  wire [3:0]  i_chop_delay_sel,
  input  wire [2:0]  i_oversampling_ratio,
  input  wire [1:0]  i_power_level_sel,
  input  wire        i_dc_test_sel,
  input  wire [2:0]  i_channel_enable,
  input  wire        i_detect_enable,
  input  wire [15:0] i_threshold_upper_reg,
  input  wire [7:0]  i_threshold_lower_reg,
  input  wire [2:0]  i_detect_window_len,
  input  wire [2:0]  i_detect_hit_count,
  input  wire        i_detect_require_all,
  // Analog front end
  input  wire [71:0] i_filter_data,
  input  wire [71:0] i_detect_data,
  input  wire        i_detect_valid,
  output reg         o_polarity_swapped,
  output reg         o_filter_reset,
  output reg         o_detect_convert,
  output reg  [2:0]  o_channels_active,
  output reg  [1:0]  o_power_level,
  output reg         o_analog_powered,
  output reg         o_phase_cal_apply,
  output reg         o_device_reset,
  output reg  [71:0] o_result
);

  localparam [3:0] ST_RUN     = 4'b0001;
  localparam [3:0] ST_STANDBY = 4'b0010;
  localparam [3:0] ST_WAKE    = 4'b0100;
  localparam [3:0] ST_DETECT  = 4'b1000;
  localparam [2:0] CP_SETTLE  = 3'b001;
  localparam [2:0] CP_DELAY   = 3'b010;
  localparam [2:0] CP_CONV    = 3'b100;
  localparam [31:0] RST_CYC_W = (`RST_PULSE_NS + `MCLK_NS - 32'd1) / `MCLK_NS;
  localparam [11:0] RST_CYC   = RST_CYC_W[11:0];

  // ==========================================
  // Pin synchronisers
  reg  [5:0]  sync1;
  reg  [5:0]  sync2;
  reg  [5:0]  sync3;
  wire        cs_n     = sync2[0];
  wire        sclk_ris = sync2[1] & ~sync3[1];
  wire        sclk_fal = ~sync2[1] & sync3[1];
  wire        din      = sync2[2];
  wire        mod_tick = sync2[3] & ~sync3[3];
  wire        syn_fal  = ~sync2[4] & sync3[4];
  wire        syn_ris  = sync2[4] & ~sync3[4];
  wire        osc_tick = sync2[5] & ~sync3[5];
  wire        cs_fal   = ~sync2[0] & sync3[0];
  wire        cs_ris   = sync2[0] & ~sync3[0];

  always @(posedge i_mclk) begin
    if (i_srst) begin
      sync1 <= 6'h3_5;
      sync2 <= 6'h3_5;
      sync3 <= 6'h3_5;
    end else begin
      sync1 <= {i_osc_clk, i_sync_reset_n, i_converter_clock_in, i_din, i_sclk, i_cs_n};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // ==========================================
  // Helpers
  function [23:0] mag;
    input [23:0] d;
    mag = d[23] ? (~d + 24'h00_0001) : d;
  endfunction

  function [11:0] win_len;
    input [2:0] sel;
    case (sel)
      3'd0:    win_len = `WIN_L0;
      3'd1:    win_len = `WIN_L1;
      3'd2:    win_len = `WIN_L2;
      3'd3:    win_len = `WIN_L3;
      3'd4:    win_len = `WIN_L4;
      3'd5:    win_len = `WIN_L5;
      3'd6:    win_len = `WIN_L6;
      default: win_len = `WIN_L7;
    endcase
  endfunction

  wire [16:0] osr_ticks = `OSR_BASE << i_oversampling_ratio;
  wire [16:0] conv_len  = i_chop_enable ? osr_ticks * `CONV_MULT : osr_ticks;
  wire [16:0] dly_len   = `DLY_BASE << i_chop_delay_sel;
  wire [23:0] thresh    = {i_threshold_upper_reg, i_threshold_lower_reg};
  wire [3:0]  need_hits = {1'b0, i_detect_hit_count} + 4'h1;

  // ==========================================
  // SPI mode 1 slave: launch on rise, sample on fall
  reg  [87:0] tx_sh;
  reg  [15:0] rx_sh;
  reg  [4:0]  rx_cnt;
  wire        cmd_done = cs_ris & rx_cnt[4];
  wire        cmd_stby = cmd_done & (rx_sh == `CMD_STANDBY);
  wire        cmd_wake = cmd_done & (rx_sh == `CMD_WAKEUP);

  assign o_dout_oe = ~cs_n;

  always @(posedge i_mclk) begin
    if (i_srst) begin
      tx_sh  <= 88'h0;
      rx_sh  <= 16'h0000;
      rx_cnt <= 5'h00;
      o_dout <= 1'b0;
    end else if (cs_fal) begin
      tx_sh  <= {`STATUS_WORD, o_result};
      rx_cnt <= 5'h00;
    end else if (!cs_n) begin
      if (sclk_ris) begin
        o_dout <= tx_sh[87];
        tx_sh  <= {tx_sh[86:0], 1'b0};
      end
      if (sclk_fal && !rx_cnt[4]) begin
        rx_sh  <= {rx_sh[14:0], din};
        rx_cnt <= rx_cnt + 5'h01;
      end
    end
  end

  // ==========================================
  // Sync/reset pin: long low resets, short low synchronises
  reg  [11:0] low_cnt;
  wire        short_pulse = syn_ris & (low_cnt < RST_CYC);

  always @(posedge i_mclk) begin
    if (i_srst) begin
      low_cnt        <= 12'h000;
      o_device_reset <= 1'b0;
    end else if (!sync2[4]) begin
      if (low_cnt < RST_CYC)
        low_cnt <= low_cnt + 12'h001;
      else
        o_device_reset <= 1'b1;
    end else begin
      low_cnt        <= 12'h000;
      o_device_reset <= 1'b0;
    end
  end

  // ==========================================
  // Current-detect counters
  reg  [3:0]  hits [0:2];
  reg  [11:0] samp_cnt;
  wire [2:0]  flag;
  wire        win_end = i_detect_valid & (samp_cnt == win_len(i_detect_window_len) - 12'h001);
  wire        any_hit = |(flag & i_channel_enable);
  wire        all_hit = (&(flag | ~i_channel_enable)) & (|i_channel_enable);
  wire        detected = i_detect_require_all ? all_hit : any_hit;

  // ==========================================
  // Mode state machine
  reg  [3:0]  state;
  reg  [3:0]  wake_cnt;
  reg  [2:0]  cp;
  reg  [16:0] cnt;
  reg  [2:0]  last_osr;
  reg         last_chop;
  reg         have_half;
  reg  [71:0] half;
  reg         data_ready_n_drop;
  wire        restart = syn_fal | (last_osr != i_oversampling_ratio)
                        | (last_chop != i_chop_enable);
  wire        publish_ok = ~(i_chop_enable & i_dc_test_sel);
  wire [71:0] avg;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : ch
      wire [24:0] sum = {half[g*24+23], half[g*24 +: 24]}
                        + {i_filter_data[g*24+23], i_filter_data[g*24 +: 24]};
      assign avg[g*24 +: 24] = sum[24:1];
      assign flag[g] = (hits[g] >= need_hits);

      always @(posedge i_mclk) begin
        if (i_srst || state != ST_DETECT || win_end || detected)
          hits[g] <= 4'h0;
        else if (i_detect_valid && i_channel_enable[g] && !flag[g]
                 && mag(i_detect_data[g*24 +: 24]) > thresh)
          hits[g] <= hits[g] + 4'h1;
      end
    end
  endgenerate

  always @(posedge i_mclk) begin
    if (i_srst || state != ST_DETECT || win_end || detected)
      samp_cnt <= 12'h000;
    else if (i_detect_valid)
      samp_cnt <= samp_cnt + 12'h001;
  end
  // Detect conversions are paced only by the internal oscillator
  always @(posedge i_mclk) begin
    if (i_srst)
      o_detect_convert <= 1'b0;
    else
      o_detect_convert <= (state == ST_DETECT) & osc_tick;
  end

  always @(posedge i_mclk) begin
    if (i_srst) begin
      state              <= ST_RUN;
      wake_cnt           <= 4'h0;
      cp                 <= CP_SETTLE;
      cnt                <= 17'h0_0000;
      last_osr           <= 3'h0;
      last_chop          <= 1'b0;
      have_half          <= 1'b0;
      half               <= 72'h0;
      o_result           <= 72'h0;
      o_polarity_swapped <= 1'b0;
      o_filter_reset     <= 1'b0;
      o_data_ready_n     <= 1'b1;
      data_ready_n_drop          <= 1'b0;
      o_channels_active  <= 3'h0;
      o_power_level      <= `PWR_MINIMAL;
      o_analog_powered   <= 1'b0;
      o_phase_cal_apply  <= 1'b0;
    end else begin
      last_osr          <= i_oversampling_ratio;
      last_chop         <= i_chop_enable;
      o_filter_reset    <= 1'b0;
      o_power_level     <= i_power_level_sel;
      o_phase_cal_apply <= ~i_chop_enable & (state == ST_RUN);
      o_analog_powered  <= (state == ST_RUN) | (state == ST_WAKE);
      o_channels_active <= (state == ST_RUN) ? i_channel_enable : 3'h0;
      // Pull high one cycle so a result that is still unread makes a fresh edge
      if (data_ready_n_drop) begin
        o_data_ready_n <= 1'b0;
        data_ready_n_drop      <= 1'b0;
      end else if (cs_ris && state != ST_STANDBY) begin
        o_data_ready_n <= 1'b1;
      end
      if (o_device_reset) begin
        state     <= ST_RUN;
        cp        <= CP_SETTLE;
        cnt       <= 17'h0_0000;
        have_half <= 1'b0;
        o_polarity_swapped <= 1'b0;
      end else begin
        case (state)
          ST_RUN: begin
            if (cmd_stby)
              state <= ST_STANDBY;
            else if (restart) begin
              cp                 <= i_chop_enable ? CP_SETTLE : CP_CONV;
              cnt                <= 17'h0_0000;
              have_half          <= 1'b0;
              o_polarity_swapped <= 1'b0;
              o_filter_reset     <= 1'b1;
            end else if (mod_tick) begin
              cnt <= cnt + 17'h0_0001;
              case (cp)
                CP_SETTLE: begin
                  if (cnt == `SETTLE_TICKS - 17'h0_0001) begin
                    cp  <= CP_DELAY;
                    cnt <= 17'h0_0000;
                  end
                end
                CP_DELAY: begin
                  if (cnt == dly_len - 17'h0_0001) begin
                    cp  <= CP_CONV;
                    cnt <= 17'h0_0000;
                  end
                end
                CP_CONV: begin
                  if (cnt == conv_len - 17'h0_0001) begin
                    cnt <= 17'h0_0000;
                    if (!i_chop_enable) begin
                      o_result       <= i_filter_data;
                      o_data_ready_n <= ~o_data_ready_n;
                      data_ready_n_drop      <= ~o_data_ready_n;
                    end else begin
                      half      <= i_filter_data;
                      have_half <= 1'b1;
                      cp        <= CP_DELAY;
                      o_polarity_swapped <= ~o_polarity_swapped;
                      o_filter_reset     <= 1'b1;
                      if (have_half && publish_ok) begin
                        o_result       <= avg;
                        o_data_ready_n <= ~o_data_ready_n;
                        data_ready_n_drop      <= ~o_data_ready_n;
                      end
                    end
                  end
                end
                default: cp <= CP_SETTLE;
              endcase
            end
          end
          ST_STANDBY: begin
            if (cmd_wake) begin
              state    <= ST_WAKE;
              wake_cnt <= 4'h0;
            end else if (short_pulse && i_detect_enable) begin
              state          <= ST_DETECT;
              o_data_ready_n <= 1'b1;
            end
          end
          ST_WAKE: begin
            if (cmd_stby)
              state <= ST_STANDBY;
            else if (mod_tick) begin
              wake_cnt <= wake_cnt + 4'h1;
              if (wake_cnt == `WAKE_TICKS - 4'h1) begin
                state              <= ST_RUN;
                cp                 <= i_chop_enable ? CP_SETTLE : CP_CONV;
                cnt                <= 17'h0_0000;
                have_half          <= 1'b0;
                o_polarity_swapped <= 1'b0;
                o_filter_reset     <= 1'b1;
              end
            end
          end
          ST_DETECT: begin
            if (!i_detect_enable || cmd_stby)
              state <= ST_STANDBY;
            else if (detected) begin
              o_data_ready_n <= 1'b0;
              state          <= ST_STANDBY;
            end
          end
          default: state <= ST_RUN;
        endcase
      end
    end
  end

endmodule

// ### rtl/adc_ctrl_map.vh
`ifndef ADC_CTRL_MAP_VH
`define ADC_CTRL_MAP_VH
// ==========================================
// Clock and timing
`define MCLK_NS         32'd8
`define RST_PULSE_NS    32'd16000
`define SETTLE_TICKS    17'h0_002C
`define WAKE_TICKS      4'h8
`define CONV_MULT       17'h0_0003
`define OSR_BASE        17'h0_0080
`define DLY_BASE        17'h0_0002
// ==========================================
// Power levels
`define PWR_HIGH_RES    2'h3
`define PWR_REDUCED     2'h1
`define PWR_MINIMAL     2'h0
// ==========================================
// Commands
`define CMD_STANDBY     16'h0022
`define CMD_WAKEUP      16'h0033
`define STATUS_WORD     16'h0500
// ==========================================
// Detect window lengths in samples
`define WIN_L0          12'h080
`define WIN_L1          12'h100
`define WIN_L2          12'h200
`define WIN_L3          12'h300
`define WIN_L4          12'h400
`define WIN_L5          12'h600
`define WIN_L6          12'h800
`define WIN_L7          12'hE00
`endif

// ### tb/adc_host_model.sv
`timescale 1ns/1ps
module adc_host_model (
  // Clock
  input  wire i_mclk,
  // Serial pins
  input  wire i_miso,
  output reg  o_sclk,
  output reg  o_cs_n,
  output reg  o_mosi
);
  reg [15:0] rx;
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
    rx     = 16'h0000;
  end
  // ==========================================
  // One command word, slow enough for the pin synchronisers
  task automatic frame(input [15:0] cmd);
    integer n;
    begin
      @(posedge i_mclk) o_cs_n <= 1'b0;
      repeat (8) @(posedge i_mclk);
      for (n = 15; n >= 0; n = n - 1) begin
        o_sclk <= 1'b1;
        o_mosi <= cmd[n];
        repeat (8) @(posedge i_mclk);
        o_sclk <= 1'b0;
        rx     <= {rx[14:0], i_miso};
        repeat (8) @(posedge i_mclk);
      end
      o_cs_n <= 1'b1;
      // Released line must not keep showing the last bit
      o_mosi <= ~cmd[0];
      repeat (8) @(posedge i_mclk);
    end
  endtask
endmodule

// ### tb/adc_ctrl_checker.sv
`timescale 1ns/1ps
module adc_ctrl_checker (
  // Clock and reset
  input wire       i_mclk,
  input wire       i_srst,
  // Inputs watched
  input wire       i_sync_reset_n,
  input wire       i_sclk,
  input wire       i_cs_n,
  input wire       i_chop_enable,
  input wire [1:0] i_power_level_sel,
  input wire       i_dc_test_sel,
  // Outputs watched
  input wire       o_dout,
  input wire       o_dout_oe,
  input wire       o_data_ready_n,
  input wire       o_polarity_swapped,
  input wire       o_filter_reset,
  input wire       o_detect_convert,
  input wire [1:0] o_power_level,
  input wire       o_analog_powered,
  input wire       o_phase_cal_apply,
  input wire       o_device_reset
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  sequence s_held_in_reset;
    o_device_reset ##0 !i_sync_reset_n;
  endsequence
  sequence s_cs_idle;
    i_cs_n [*4];
  endsequence
  chk_filter_pulse: assert property (o_filter_reset |=> !o_filter_reset)
    else $error("filter reset longer than one cycle");
  chk_swap_resets: assert property (!$past(i_srst) && $changed(o_polarity_swapped)
    |-> o_filter_reset || $past(o_filter_reset)) else $error("swap without filter reset");
  chk_phase_off: assert property (i_chop_enable [*2] |-> !o_phase_cal_apply)
    else $error("phase calibration applied while chopping");
  chk_power_follow: assert property (!$past(i_srst) && o_analog_powered
    && $past(o_analog_powered) |-> o_power_level == $past(i_power_level_sel))
    else $error("power level does not follow selection");
  chk_cs_idle_oe: assert property (s_cs_idle |-> !o_dout_oe)
    else $error("data out driven while deselected");
  chk_dout_still: assert property ((i_sclk && !i_cs_n) [*6] |-> $stable(o_dout))
    else $error("data out changed away from clock rise");
  chk_detect_pulse: assert property (o_detect_convert |=> !o_detect_convert)
    else $error("detect request longer than one cycle");
  chk_reset_holds: assert property (s_held_in_reset |=> o_device_reset)
    else $error("reset left while pin low");
  chk_reset_clears: assert property (i_sync_reset_n [*8] |-> !o_device_reset)
    else $error("reset kept while pin high");
  chk_dc_blocked: assert property ((i_chop_enable && i_dc_test_sel) [*4]
    |-> !$fell(o_data_ready_n)) else $error("test signal result published");
endmodule

bind adc_chop_standby_detect_ctrl adc_ctrl_checker u_chk (.*);

// ### tb/tb_top.sv
`timescale 1ns/1ps
`include "adc_ctrl_map.vh"
module tb_top;
  // ==========================================
  // Stimulus and observed signals
  reg         i_mclk = 1'b0, i_srst = 1'b1, i_converter_clock_in = 1'b0, i_osc_clk = 1'b0;
  reg         i_sync_reset_n = 1'b1, i_chop_enable = 1'b0, i_dc_test_sel = 1'b0;
  reg         i_detect_enable = 1'b0, i_detect_require_all = 1'b0, i_detect_valid = 1'b0;
  reg  [3:0]  i_chop_delay_sel = 4'h0;
  reg  [1:0]  i_power_level_sel = `PWR_HIGH_RES;
  reg  [2:0]  i_channel_enable = 3'h7, i_detect_hit_count = 3'h0;
  reg  [71:0] i_filter_data = 72'h0, i_detect_data = 72'h0;
  wire [2:0]  i_oversampling_ratio = 3'h0, i_detect_window_len = 3'h0;
  wire [15:0] i_threshold_upper_reg = 16'h0001;
  wire [7:0]  i_threshold_lower_reg = 8'h00;
  wire        i_sclk, i_cs_n, i_din, o_dout, o_dout_oe, o_data_ready_n, o_polarity_swapped;
  wire        o_filter_reset, o_detect_convert, o_analog_powered, o_phase_cal_apply;
  wire        o_device_reset;
  wire [2:0]  o_channels_active;
  wire [1:0]  o_power_level;
  wire [71:0] o_result;
  integer     failures = 0, checked = 0, ticks = 0, t0, n;
  reg  [31:0] seed = 32'h0000_0035;

  adc_chop_standby_detect_ctrl dut (.*);
  adc_host_model host (.i_mclk(i_mclk), .i_miso(o_dout), .o_sclk(i_sclk), .o_cs_n(i_cs_n),
                       .o_mosi(i_din));

  always #4 i_mclk = ~i_mclk;
  // Odd offsets keep the slow clocks off the system clock edges
  initial #3 forever #32 i_converter_clock_in = ~i_converter_clock_in;
  initial #1 forever #400 i_osc_clk = ~i_osc_clk;
  always @(posedge i_converter_clock_in) ticks = ticks + 1;
  always @(posedge i_mclk) i_detect_valid <= o_detect_convert;

  // ==========================================
  // Helpers
  function [31:0] xs(input [31:0] s);
    reg [31:0] x;
    begin
      x  = s ^ (s << 13);
      x  = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  function integer exp_ticks(input integer first, input [3:0] sel);
    exp_ticks = (first + 1) * ((2 << sel) + 3 * 128) + first * 44;
  endfunction
  task chk_val(input string name, input [71:0] exp, input [71:0] got);
    begin
      #1;
      checked = checked + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[FAIL] %0s expected %0h seen %0h", name, exp, got);
      end
    end
  endtask
  task chk_cnt(input string name, input integer exp, input integer got);
    chk_val(name, exp, got);
  endtask
  task wrap_up;
    begin
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask

  // ==========================================
  // Tests
  initial begin
    repeat (8) @(posedge i_mclk);
    i_srst <= 1'b0;
    seed = xs(seed);
    i_chop_delay_sel <= {2'b00, seed[1:0]};
    i_filter_data <= {3{seed[31:8]}};
    @(posedge i_mclk) i_sync_reset_n <= 1'b0;
    repeat (2100) @(posedge i_mclk);
    chk_val("device_reset", 1, o_device_reset);
    @(posedge i_mclk) i_sync_reset_n <= 1'b1;
    repeat (10) @(posedge i_mclk);
    chk_val("device_reset", 0, o_device_reset);
    $display("test pin_reset done");
    @(posedge i_mclk) i_chop_enable <= 1'b1;
    repeat (40) @(posedge i_mclk);
    @(posedge i_converter_clock_in);
    repeat (2) @(posedge i_mclk);
    i_sync_reset_n <= 1'b0;
    t0 = ticks;
    repeat (20) @(posedge i_mclk);
    i_sync_reset_n <= 1'b1;
    @(negedge o_data_ready_n);
    chk_cnt("first_ticks", exp_ticks(1, i_chop_delay_sel), ticks - t0);
    chk_val("result", i_filter_data, o_result);
    t0 = ticks;
    @(negedge o_data_ready_n);
    chk_cnt("period_ticks", exp_ticks(0, i_chop_delay_sel), ticks - t0);
    for (n = 0; n < 3; n = n + 1) begin
      @(posedge i_mclk) i_power_level_sel <= n == 0 ? `PWR_REDUCED : n == 1 ? `PWR_MINIMAL
                                                                             : `PWR_HIGH_RES;
      repeat (3) @(posedge i_mclk);
      chk_val("power_level", i_power_level_sel, o_power_level);
    end
    @(posedge i_mclk) i_dc_test_sel <= 1'b1;
    repeat (3300) @(posedge i_mclk);
    i_dc_test_sel <= 1'b0;
    $display("test chop done");
    host.frame(`CMD_STANDBY);
    chk_val("status", `STATUS_WORD, host.rx);
    chk_val("channels", 0, o_channels_active);
    chk_val("powered", 0, o_analog_powered);
    host.frame(`CMD_WAKEUP);
    repeat (12) @(posedge i_converter_clock_in);
    chk_val("powered", 1, o_analog_powered);
    $display("test standby done");
    host.frame(`CMD_STANDBY);
    seed = xs(seed);
    @(posedge i_mclk) i_detect_enable <= 1'b1;
    i_detect_hit_count <= seed[2:0];
    i_detect_require_all <= seed[3];
    i_channel_enable <= seed[3] ? 3'h1 : 3'h7;
    i_detect_data <= {24'h00_0010, 24'h00_0010, 24'hFF_F000};
    i_sync_reset_n <= 1'b0;
    repeat (20) @(posedge i_mclk);
    i_sync_reset_n <= 1'b1;
    t0 = 0;
    while (o_data_ready_n === 1'b1) begin
      @(posedge i_mclk);
      #1;
      if (i_detect_valid) t0 = t0 + 1;
    end
    chk_cnt("hits", i_detect_hit_count + 1, t0);
    chk_val("channels", 0, o_channels_active);
    $display("test detect done");
    wrap_up;
  end

  initial begin
    #(8 * 60000);
    failures = failures + 1;
    wrap_up;
  end
endmodule
